// *** dv/nvm_command_decoder_props.sv ***
// Concurrent checks on the pins of the command sequencer.
`timescale 1ns/1ps
module nvm_command_decoder_props (
    input wire logic SYS_CLK, RST, REQ_VALID, REQ_READY, DONE, REFUSED,
    input wire nvm_pkg::req_s REQ,
    input wire logic CODE_FROM_EEPROM, ERASE_WINDOW_OPEN, OTP_READ_MODE, WR_N, RD_N,
    input wire logic [7:0] CODE_FROM_FLASH, DATA_O, FLASH_SECTOR_SELECT,
    input wire logic [15:0] ADDR,
    input wire logic [3:0] EEPROM_SECTOR_SELECT
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    wire take = REQ_VALID && REQ_READY;
    wire ee_sel = |EEPROM_SECTOR_SELECT;
    chk_strobe_excl: assert property (WR_N || RD_N) else $error("strobes overlap");
    chk_done_pulse: assert property (DONE |=> !DONE) else $error("done too long");
    chk_refuse_done: assert property (REFUSED |-> DONE) else $error("lone refuse");
    chk_ee_code: assert property (take && CODE_FROM_EEPROM &&
        REQ.cmd == nvm_pkg::CMD_EE_POWER_DOWN |-> ##2 REFUSED) else $error("ee run");
    chk_flash_code: assert property (take && CODE_FROM_FLASH[REQ.sector] &&
        REQ.cmd == nvm_pkg::CMD_PROGRAM |-> ##2 REFUSED) else $error("flash run");
    chk_one_array: assert property (!(|FLASH_SECTOR_SELECT && ee_sel))
        else $error("both arrays");
    chk_unlock_addr: assert property (!WR_N && DATA_O == 8'haa |->
        ADDR[11:0] == 12'h555) else $error("unlock address");
    chk_otp_a6: assert property (OTP_READ_MODE && !RD_N && ee_sel |-> !ADDR[6])
        else $error("row address");
    chk_window_shut: assert property (take && !ERASE_WINDOW_OPEN &&
        REQ.cmd == nvm_pkg::CMD_ADD_SECTOR |-> ##2 REFUSED) else $error("late add");
endmodule : nvm_command_decoder_props
bind nvm_command_decoder nvm_command_decoder_props u_props (.*);

// *** dv/nvm_device_model.sv ***
// Behavioural flash and EEPROM device answering the sequencer's bus cycles.
`timescale 1ns/1ps
module nvm_device_model #(
    parameter logic [7:0] ID_CODE = 8'h5c, // Arbitrary identifier value.
    parameter logic [7:0] PROT = 8'h08
) (
    input wire logic [15:0] addr,
    input wire logic [7:0] data_o, fsel,
    input wire logic wr_n, rd_n,
    input wire logic [3:0] esel,
    output logic [7:0] data_i
);
    logic [7:0] mem [256];
    logic [7:0] otp [64];
    logic [47:0] fh = '0;
    logic [47:0] eh = '0;
    logic software_write_protect = 0, otp_rd = 0, otp_wr = 0;
    int n_er = 0;
    wire [47:0] ne = {eh[39:0], data_o};
    wire id_mode = fh[23:0] == 24'haa5590;
    wire [7:0] q = id_mode ? (addr[1] ? {7'h0, |(fsel & PROT)} : ID_CODE)
        : (otp_rd && |esel) ? otp[addr[5:0]] : mem[addr[7:0]];
    // Released bus shows the inverse so stale data cannot pass.
    assign data_i = rd_n ? ~q : q;
    always @(posedge wr_n) begin
        if (|fsel) begin
            if (fh[23:0] == 24'haa55a0) mem[addr[7:0]] <= data_o;
            if (data_o == 8'h30) n_er <= n_er + 1;
            fh <= {fh[39:0], data_o};
        end else if (|esel) begin
            if (otp_wr) otp[addr[5:0]] <= data_o;
            if (ne[23:0] == 24'haa55a0) software_write_protect <= 1'b1;
            if (ne == 48'haa5580aa5520) software_write_protect <= 1'b0;
            otp_rd <= ne[23:0] == 24'haa5590 || (otp_rd && data_o != 8'hf0);
            otp_wr <= (ne[23:0] == 24'haa55b0 && !software_write_protect) || (otp_wr && data_o != 8'hf0);
            eh <= ne;
        end
    end
endmodule : nvm_device_model

// *** dv/tb_nvm_command_decoder.sv ***
// Self-checking bench for the flash and EEPROM command sequencer.
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fail_count++; \
    $display("BAD %0t got %h want %h", $time, a, b); end end
module tb_nvm_command_decoder;
    logic SYS_CLK = 0, RST = 1, REQ_VALID = 0, CODE_FROM_EEPROM = 0;
    logic [7:0] CODE_FROM_FLASH = 8'h00;
    nvm_pkg::req_s REQ = '0;
    wire REQ_READY, DONE, REFUSED, ERASE_WINDOW_OPEN, FLASH_BUSY, ERROR_STATUS_BIT;
    wire SOFTWARE_WRITE_PROTECT, OTP_READ_MODE, EE_POWERED_DOWN, DATA_OE, WR_N, RD_N;
    wire [7:0] RD_DATA, DATA_O, DATA_I, FLASH_SECTOR_SELECT;
    wire [15:0] ADDR;
    wire [3:0] EEPROM_SECTOR_SELECT;
    int fail_count = 0, check_count = 0;
    nvm_command_decoder u_dut (.*);
    nvm_device_model u_dev (.addr(ADDR), .data_o(DATA_O), .fsel(FLASH_SECTOR_SELECT),
        .wr_n(WR_N), .rd_n(RD_N), .esel(EEPROM_SECTOR_SELECT), .data_i(DATA_I));
    always #20 SYS_CLK = ~SYS_CLK;
    task automatic go(nvm_pkg::cmd_e c, logic e, logic [2:0] s, logic [15:0] a = 16'h0000,
        logic r = 1'b0);
        int n;
        @(posedge SYS_CLK);
        REQ_VALID <= 1'b1;
        REQ <= '{c, e, s, a, (c == nvm_pkg::CMD_PROGRAM) ? 8'h5a : 8'h3c};
        @(posedge SYS_CLK);
        REQ_VALID <= 1'b0;
        for (n = 0; n < 300 && DONE !== 1'b1; n++) @(negedge SYS_CLK);
        `CHK({DONE, REFUSED}, {1'b1, r})
    endtask : go
    task automatic t_flash;
        go(nvm_pkg::CMD_READ_ID, 0, 3'd2, 16'h8000);
        `CHK(RD_DATA, 8'h5c)
        go(nvm_pkg::CMD_READ_PROT, 0, 3'd3, 16'hc000);
        `CHK(RD_DATA, 8'h01)
        go(nvm_pkg::CMD_READ_PROT, 0, 3'd0);
        `CHK(RD_DATA, 8'h00)
        go(nvm_pkg::CMD_PROGRAM, 0, 3'd1, 16'hf042);
        `CHK(u_dev.mem[8'h42], 8'h5a)
        go(nvm_pkg::CMD_FLASH_RESET_LONG, 0, 3'd1, 16'h4000);
        `CHK(u_dev.fh[23:0], 24'haa55f0)
        go(nvm_pkg::CMD_PLAIN_READ, 0, 3'd1, 16'h4042);
        `CHK(RD_DATA, 8'h5a)
        $display("t_flash done");
    endtask : t_flash
    task automatic t_erase;
        go(nvm_pkg::CMD_SECTOR_ERASE, 0, 3'd4, 16'h1234);
        `CHK(u_dev.fh, 48'haa5580aa5530)
        go(nvm_pkg::CMD_ADD_SECTOR, 0, 3'd5, 16'h2345);
        `CHK(u_dev.n_er, 2)
        go(nvm_pkg::CMD_SUSPEND, 0, 3'd4, 16'h0777);
        `CHK(u_dev.fh[7:0], 8'hb0)
        go(nvm_pkg::CMD_RESUME, 0, 3'd4, 16'h0777);
        `CHK(u_dev.n_er, 3)
        repeat (2050) @(posedge SYS_CLK);
        go(nvm_pkg::CMD_ADD_SECTOR, 0, 3'd6, 16'h3000, 1);
        go(nvm_pkg::CMD_FLASH_RESET_SHORT, 0, 3'd4, 16'h1000);
        `CHK(FLASH_BUSY, 1'b0)
        go(nvm_pkg::CMD_CHIP_ERASE, 0, 3'd0);
        `CHK(u_dev.fh, 48'haa5580aa5510)
        go(nvm_pkg::CMD_FLASH_RESET_SHORT, 0, 3'd0);
        $display("t_erase done");
    endtask : t_erase
    task automatic t_eeprom;
        go(nvm_pkg::CMD_EE_POWER_DOWN, 1, 3'd1, 16'h2000);
        `CHK(u_dev.eh[23:0], 24'haa5530)
        go(nvm_pkg::CMD_EE_RETURN, 1, 3'd1);
        `CHK(EE_POWERED_DOWN, 1'b0)
        go(nvm_pkg::CMD_SDP_WRITE_ENTER, 1, 3'd1);
        `CHK(u_dev.software_write_protect, 1'b1)
        go(nvm_pkg::CMD_OTP_WRITE_ENTER, 1, 3'd1, 16'h0000, 1);
        go(nvm_pkg::CMD_SDP_DISABLE, 1, 3'd1);
        `CHK(u_dev.software_write_protect, 1'b0)
        go(nvm_pkg::CMD_OTP_WRITE_ENTER, 1, 3'd1);
        go(nvm_pkg::CMD_PLAIN_WRITE, 1, 3'd1, 16'h0005);
        `CHK(u_dev.otp[5], 8'h3c)
        go(nvm_pkg::CMD_EE_RETURN, 1, 3'd1);
        go(nvm_pkg::CMD_OTP_READ_ENTER, 1, 3'd1);
        go(nvm_pkg::CMD_PLAIN_READ, 1, 3'd1, 16'h0045);
        `CHK(RD_DATA, 8'h3c)
        go(nvm_pkg::CMD_EE_RETURN, 1, 3'd1);
        `CHK(OTP_READ_MODE, 1'b0)
        $display("t_eeprom done");
    endtask : t_eeprom
    task automatic t_code;
        CODE_FROM_EEPROM <= 1'b1;
        go(nvm_pkg::CMD_EE_POWER_DOWN, 1, 3'd0, 16'h0000, 1);
        CODE_FROM_EEPROM <= 1'b0;
        CODE_FROM_FLASH <= 8'h02;
        go(nvm_pkg::CMD_PROGRAM, 0, 3'd1, 16'h0077, 1);
        CODE_FROM_FLASH <= 8'h00;
        $display("t_code done");
    endtask : t_code
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : test_done
    initial begin
        repeat (8) @(posedge SYS_CLK);
        RST <= 1'b0;
        t_flash;
        t_erase;
        t_eeprom;
        t_code;
        test_done;
    end
    initial begin
        #(40 * 20000);
        fail_count++;
        test_done;
    end
endmodule : tb_nvm_command_decoder

// *** hw/nvm_bus_cycle.sv ***
// One microcontroller-style read or write cycle on the memory pins.
`timescale 1ns/1ps

module nvm_bus_cycle #(
    parameter int SETUP_CYC = 1,
    parameter int STROBE_CYC = 2,
    parameter int HOLD_CYC = 1
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Cycle request and answer.
    input wire logic start,
    input wire nvm_pkg::cycle_s cyc,
    output logic done,
    output logic [7:0] rdata,
    // Memory pins.
    output logic [15:0] addr,
    output logic [7:0] data_o,
    output logic data_oe,
    input wire logic [7:0] data_i,
    output logic wr_n,
    output logic rd_n,
    output logic [7:0] fsel,
    output logic [3:0] esel
);

    localparam logic [7:0] STROBE_ON = 8'(SETUP_CYC);
    localparam logic [7:0] STROBE_OFF = 8'(SETUP_CYC + STROBE_CYC);
    localparam logic [7:0] LAST = 8'(SETUP_CYC + STROBE_CYC + HOLD_CYC - 1);

    logic busy;
    logic [7:0] cnt;
    nvm_pkg::cycle_s hold;

    wire strobe_on = busy && cnt >= STROBE_ON && cnt < STROBE_OFF;
    wire sample = busy && cnt == STROBE_OFF - 8'h01 && hold.is_read;
    wire finish = busy && cnt == LAST;

    // Selects are low between cycles so no stray strobe edge lands in a sector.
    always_ff @(posedge clk) begin
        if (rst) begin
            busy <= 1'b0;
            cnt <= 8'h00;
            hold <= '0;
            done <= 1'b0;
            rdata <= 8'h00;
        end else begin
            done <= finish;
            if (start && !busy) begin
                busy <= 1'b1;
                cnt <= 8'h00;
                hold <= cyc;
            end else if (finish) begin
                busy <= 1'b0;
            end else if (busy) begin
                cnt <= cnt + 8'h01;
            end
            if (sample) begin
                rdata <= data_i;
            end
        end
    end

    assign addr = busy ? hold.addr : 16'h0000;
    assign data_o = busy ? hold.data : 8'h00;
    assign data_oe = busy && !hold.is_read;
    assign wr_n = !(strobe_on && !hold.is_read);
    assign rd_n = !(strobe_on && hold.is_read);
    assign fsel = busy ? hold.fsel : 8'h00;
    assign esel = busy ? hold.esel : 4'h0;

endmodule : nvm_bus_cycle

// *** hw/nvm_command_decoder.sv ***
// Host sequencer that drives flash and EEPROM command sequences over the memory bus.
//
// Function
// RL1: Flash unlock, 90h, then read at A6,A1,A0=0,0,1 gives the identifier.
// RL2: Same preamble, read at A6,A1,A0=0,1,0 gives sector protection.
// RL3: EEPROM-selected AA, 55, 90 at 555 switches reads to the one-time row.
// RL4: Flash program is AA, 55, A0 at unlock addresses, then data at target.
// RL5: Sector erase is six writes ending with 30h at any sector address.
// RL6: Extra 30h sector writes count only within 80 us of the previous.
// RL7: Whole flash erase is the five-write unlock followed by 10h at 555.
// RL8: A single flash-selected B0h write anywhere suspends sector erase.
// RL9: A single flash-selected 30h write anywhere resumes sector erase.
// RL10: EEPROM-selected AA, 55, 30h at 555 powers the EEPROM down.
// RL11: EEPROM-selected AA, 55, A0h at 555 enables write protection; bytes follow.
// RL12: Write protection is disabled by the five-write unlock then 20h at 555.
// RL13: EEPROM-selected AA, 55, B0h at 555 stores following bytes in one-time row.
// RL14: One-time row writes are accepted only while write protection is off.
// RL15: A single EEPROM-selected F0h leaves one-time row read or power-down.
// RL16: Flash reset is either AA, 55, F0h or a single F0h write.
// RL17: Flash reset follows an error bit, identifier or protection read.
// RL18: Selects active high; only low twelve bits form unlock addresses.
// RL19: Controller runs from other memory while issuing any EEPROM command.
// RL20: Controller never runs from the flash sector its command targets.
// RL21: Bad byte or long gap returns the flash decoder to read mode.
// RL22: Bad EEPROM byte or long gap is treated as an ordinary write.
// RL23: Protection read returns 01h for protected and 00h for unprotected.
// RL24: One-time row reads hold A6 low and choose a byte with A5-A0.
// RL25: Inter-byte timeout is a cycle-count parameter; the sequencer has no such timeout.
// RL26: Flash and EEPROM progress is tracked apart by active select.
`timescale 1ns/1ps

`include "nvm_defs.svh"

module nvm_command_decoder #(
    parameter int SETUP_CYC = 1,
    parameter int STROBE_CYC = 2,
    parameter int HOLD_CYC = 1
) (
    // Clock and reset.
    input wire logic SYS_CLK,
    input wire logic RST,
    // Command request from the user logic.
    input wire logic REQ_VALID,
    output logic REQ_READY,
    input wire nvm_pkg::req_s REQ,
    // Command completion.
    output logic DONE,
    output logic REFUSED,
    output logic [7:0] RD_DATA,
    // Where the processor currently fetches its code.
    input wire logic CODE_FROM_EEPROM,
    input wire logic [7:0] CODE_FROM_FLASH,
    // Tracked device state.
    output logic ERASE_WINDOW_OPEN,
    output logic FLASH_BUSY,
    output logic ERROR_STATUS_BIT,
    output logic SOFTWARE_WRITE_PROTECT,
    output logic OTP_READ_MODE,
    output logic EE_POWERED_DOWN,
    // Memory pins.
    output logic [15:0] ADDR,
    output logic [7:0] DATA_O,
    output logic DATA_OE,
    input wire logic [7:0] DATA_I,
    output logic WR_N,
    output logic RD_N,
    output logic [7:0] FLASH_SECTOR_SELECT,
    output logic [3:0] EEPROM_SECTOR_SELECT
);

    ////////////////////////////////////////////////////////////////////////////
    // Command step table.

    // Returns step i of a command; after preamble steps 0 and 1 the table branches.
    function automatic nvm_pkg::step_s step_of(nvm_pkg::cmd_e c, logic [2:0] i, logic [7:0] d);
        nvm_pkg::step_s s;
        s = '{last: 1'b1, is_read: 1'b0, akind: nvm_pkg::ADR_USER, data: d};
        if (i == 3'h0 || i == 3'h3) begin
            s = '{last: 1'b0, is_read: 1'b0, akind: nvm_pkg::ADR_UNLOCK1, data: `NVM_UNLOCK1};
        end else if (i == 3'h1 || i == 3'h4) begin
            s = '{last: 1'b0, is_read: 1'b0, akind: nvm_pkg::ADR_UNLOCK2, data: `NVM_UNLOCK2};
        end
        case (c)
            nvm_pkg::CMD_READ_ID, nvm_pkg::CMD_READ_PROT: begin
                if (i == 3'h2) begin
                    s = '{last: 1'b0, is_read: 1'b0, akind: nvm_pkg::ADR_UNLOCK1,
                          data: `NVM_AUTOSEL}; // see RL1
                end else if (i == 3'h3) begin
                    s = '{last: 1'b0, is_read: 1'b1,
                          akind: (c == nvm_pkg::CMD_READ_ID) ? nvm_pkg::ADR_ID
                                                             : nvm_pkg::ADR_PROT,
                          data: 8'h00}; // see RL2
                end else if (i == 3'h4) begin
                    s = '{last: 1'b1, is_read: 1'b0, akind: nvm_pkg::ADR_USER,
                          data: `NVM_RETURN}; // see RL17
                end
            end
            nvm_pkg::CMD_OTP_READ_ENTER, nvm_pkg::CMD_EE_POWER_DOWN,
            nvm_pkg::CMD_SDP_WRITE_ENTER, nvm_pkg::CMD_OTP_WRITE_ENTER,
            nvm_pkg::CMD_PROGRAM, nvm_pkg::CMD_FLASH_RESET_LONG: begin
                if (i == 3'h2) begin
                    s.last = (c != nvm_pkg::CMD_PROGRAM);
                    s.akind = (c == nvm_pkg::CMD_FLASH_RESET_LONG) ? nvm_pkg::ADR_USER
                                                                   : nvm_pkg::ADR_UNLOCK1;
                    case (c)
                        nvm_pkg::CMD_OTP_READ_ENTER: s.data = `NVM_AUTOSEL; // see RL3
                        nvm_pkg::CMD_EE_POWER_DOWN: s.data = `NVM_EE_POWER_DOWN; // see RL10
                        nvm_pkg::CMD_SDP_WRITE_ENTER: s.data = `NVM_PROGRAM; // see RL11
                        nvm_pkg::CMD_OTP_WRITE_ENTER: s.data = `NVM_OTP_WRITE; // see RL13
                        nvm_pkg::CMD_PROGRAM: s.data = `NVM_PROGRAM; // see RL4
                        default: s.data = `NVM_RETURN; // see RL16
                    endcase
                end else if (i == 3'h3) begin
                    s = '{last: 1'b1, is_read: 1'b0, akind: nvm_pkg::ADR_USER, data: d};
                end
            end
            nvm_pkg::CMD_SECTOR_ERASE, nvm_pkg::CMD_CHIP_ERASE, nvm_pkg::CMD_SDP_DISABLE: begin
                if (i == 3'h2) begin
                    s = '{last: 1'b0, is_read: 1'b0, akind: nvm_pkg::ADR_UNLOCK1,
                          data: `NVM_ERASE_SETUP};
                end else if (i == 3'h5) begin
                    s.last = 1'b1;
                    s.akind = nvm_pkg::ADR_UNLOCK1;
                    case (c)
                        nvm_pkg::CMD_SECTOR_ERASE: begin
                            s.akind = nvm_pkg::ADR_USER;
                            s.data = `NVM_SECTOR_ERASE; // see RL5
                        end
                        nvm_pkg::CMD_CHIP_ERASE: s.data = `NVM_CHIP_ERASE; // see RL7
                        default: s.data = `NVM_SDP_OFF; // see RL12
                    endcase
                end
            end
            nvm_pkg::CMD_ADD_SECTOR: s.data = `NVM_SECTOR_ERASE; // see RL6
            nvm_pkg::CMD_SUSPEND: s.data = `NVM_SUSPEND; // see RL8
            nvm_pkg::CMD_RESUME: s.data = `NVM_RESUME; // see RL9
            nvm_pkg::CMD_EE_RETURN, nvm_pkg::CMD_FLASH_RESET_SHORT: begin
                s.data = `NVM_RETURN; // see RL15
            end
            nvm_pkg::CMD_PLAIN_READ: s.is_read = 1'b1;
            default: s.data = d;
        endcase
        // Single-cycle commands carry no preamble, so the unlock defaults are undone.
        if (c inside {nvm_pkg::CMD_ADD_SECTOR, nvm_pkg::CMD_SUSPEND, nvm_pkg::CMD_RESUME,
            nvm_pkg::CMD_EE_RETURN, nvm_pkg::CMD_FLASH_RESET_SHORT, nvm_pkg::CMD_PLAIN_READ,
            nvm_pkg::CMD_PLAIN_WRITE}) begin
            s.last = 1'b1;
            s.akind = nvm_pkg::ADR_USER;
        end
        return s;
    endfunction : step_of

    ////////////////////////////////////////////////////////////////////////////
    // Request classification and refusal.

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ISSUE = 4'b0010,
        ST_WAIT = 4'b0100,
        ST_DONE = 4'b1000
    } state_e;

    state_e state;
    state_e next_state;
    nvm_pkg::req_s cur;
    logic [2:0] idx;
    logic refused;
    logic [11:0] window_cnt;
    logic toggle_prev;
    logic toggle_prev_ok;
    nvm_pkg::cycle_s cyc;
    logic cyc_done;
    logic [7:0] cyc_rdata;

    localparam logic [11:0] WINDOW_LOAD = 12'(`NVM_ERASE_WINDOW_CYC);
    localparam logic [11:0] CYCLE_LEN = 12'(SETUP_CYC + STROBE_CYC + HOLD_CYC);

    wire nvm_pkg::cmd_e c = REQ.cmd;
    wire ee_cmd = c inside {nvm_pkg::CMD_OTP_READ_ENTER, nvm_pkg::CMD_EE_POWER_DOWN,
                            nvm_pkg::CMD_SDP_WRITE_ENTER, nvm_pkg::CMD_SDP_DISABLE,
                            nvm_pkg::CMD_OTP_WRITE_ENTER, nvm_pkg::CMD_EE_RETURN};
    wire plain_cmd = c inside {nvm_pkg::CMD_PLAIN_READ, nvm_pkg::CMD_PLAIN_WRITE};
    wire flash_reset = c inside {nvm_pkg::CMD_FLASH_RESET_LONG, nvm_pkg::CMD_FLASH_RESET_SHORT};
    wire to_eeprom = ee_cmd || (plain_cmd && REQ.is_eeprom);
    wire [7:0] sector_bit = 8'h01 << REQ.sector;
    wire window_ok = window_cnt > CYCLE_LEN;

    // Firmware running out of the target memory would lose its own fetches.
    wire refuse_src = to_eeprom ? CODE_FROM_EEPROM // see RL19
                                : |(CODE_FROM_FLASH & sector_bit); // see RL20
    wire refuse_otp = c == nvm_pkg::CMD_OTP_WRITE_ENTER && SOFTWARE_WRITE_PROTECT; // see RL14
    wire refuse_add = c == nvm_pkg::CMD_ADD_SECTOR && !window_ok; // see RL6
    wire refuse_err = ERROR_STATUS_BIT && !to_eeprom && !plain_cmd && !flash_reset; // see RL17
    wire refuse = refuse_src || refuse_otp || refuse_add || refuse_err;

    ////////////////////////////////////////////////////////////////////////////
    // Step decode into one bus cycle.

    wire nvm_pkg::step_s step = step_of(cur.cmd, idx, cur.data);
    wire [15:0] unlock_hi = {cur.addr[15:`NVM_CMD_ADDR_W], `NVM_CMD_ADDR_W'(0)};
    wire [15:0] id_addr = 16'h0000 | (16'h0001 << `NVM_A0);
    wire [15:0] prot_addr = 16'h0000 | (16'h0001 << `NVM_A1);
    wire [15:0] otp_addr = {10'h000, cur.addr[`NVM_OTP_IDX_W-1:0]}; // see RL24
    wire otp_read = OTP_READ_MODE && cur.is_eeprom && step.is_read;
    wire ee_target = cur.is_eeprom;
    wire [15:0] id_hi = {cur.addr[15:`NVM_A6+1], 1'b0, cur.addr[`NVM_A6-1:2], 2'b00};

    logic [15:0] step_addr;
    always_comb begin
        case (step.akind)
            nvm_pkg::ADR_UNLOCK1: step_addr = unlock_hi | 16'(`NVM_ADDR_UNLOCK1); // see RL18
            nvm_pkg::ADR_UNLOCK2: step_addr = unlock_hi | 16'(`NVM_ADDR_UNLOCK2); // see RL18
            nvm_pkg::ADR_ID: step_addr = id_hi | id_addr; // see RL1
            nvm_pkg::ADR_PROT: step_addr = id_hi | prot_addr; // see RL23
            default: step_addr = otp_read ? otp_addr : cur.addr;
        endcase
    end

    // One select is held for the whole sequence, so the two arrays never interleave.
    assign cyc.is_read = step.is_read;
    assign cyc.addr = step_addr;
    assign cyc.data = step.data;
    assign cyc.fsel = ee_target ? 8'h00 : 8'h01 << cur.sector; // see RL26
    assign cyc.esel = ee_target ? 4'h1 << cur.sector[1:0] : 4'h0; // see RL26

    nvm_bus_cycle #(
        .SETUP_CYC(SETUP_CYC),
        .STROBE_CYC(STROBE_CYC),
        .HOLD_CYC(HOLD_CYC)
    ) u_cycle (
        .clk(SYS_CLK),
        .rst(RST),
        .start(state == ST_ISSUE),
        .cyc(cyc),
        .done(cyc_done),
        .rdata(cyc_rdata),
        .addr(ADDR),
        .data_o(DATA_O),
        .data_oe(DATA_OE),
        .data_i(DATA_I),
        .wr_n(WR_N),
        .rd_n(RD_N),
        .fsel(FLASH_SECTOR_SELECT),
        .esel(EEPROM_SECTOR_SELECT)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer.

    wire accept = state == ST_IDLE && REQ_VALID;
    wire seq_end = state == ST_WAIT && cyc_done && step.last;
    wire read_back = state == ST_WAIT && cyc_done && step.is_read;
    wire poll = read_back && FLASH_BUSY && !ee_target && cur.cmd == nvm_pkg::CMD_PLAIN_READ;
    wire toggling = toggle_prev_ok && cyc_rdata[`NVM_TOGGLE_BIT] != toggle_prev;
    wire starts_op = cur.cmd inside {nvm_pkg::CMD_PROGRAM, nvm_pkg::CMD_SECTOR_ERASE,
        nvm_pkg::CMD_CHIP_ERASE, nvm_pkg::CMD_RESUME, nvm_pkg::CMD_ADD_SECTOR};
    wire cur_reset = cur.cmd inside {nvm_pkg::CMD_FLASH_RESET_LONG,
        nvm_pkg::CMD_FLASH_RESET_SHORT};

    always_comb begin
        case (state)
            ST_IDLE: next_state = !REQ_VALID ? ST_IDLE : refuse ? ST_DONE : ST_ISSUE;
            ST_ISSUE: next_state = ST_WAIT;
            ST_WAIT: next_state = !cyc_done ? ST_WAIT : step.last ? ST_DONE : ST_ISSUE;
            ST_DONE: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    assign REQ_READY = state == ST_IDLE;
    assign ERASE_WINDOW_OPEN = window_ok;

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            state <= ST_IDLE;
            cur <= '0;
            idx <= 3'h0;
            refused <= 1'b0;
        end else begin
            state <= next_state;
            if (accept) begin
                cur <= REQ;
                cur.is_eeprom <= to_eeprom;
                idx <= 3'h0;
                refused <= refuse;
            end else if (state == ST_WAIT && cyc_done) begin
                idx <= idx + 3'h1;
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            DONE <= 1'b0;
            REFUSED <= 1'b0;
            RD_DATA <= 8'h00;
        end else begin
            DONE <= state == ST_DONE;
            REFUSED <= state == ST_DONE && refused;
            if (read_back) begin
                RD_DATA <= cyc_rdata;
            end
        end
    end

    // Sector-add window restarts at every erase write that lands in time.
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            window_cnt <= 12'h000;
        end else if (seq_end && cur.cmd inside {nvm_pkg::CMD_SECTOR_ERASE,
                                               nvm_pkg::CMD_ADD_SECTOR}) begin
            window_cnt <= WINDOW_LOAD; // see RL6
        end else if (window_cnt != 12'h000) begin
            window_cnt <= window_cnt - 12'h001;
        end
    end

    // Busy ends when the toggle bit stops; an error seen while toggling needs a reset.
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            FLASH_BUSY <= 1'b0;
            ERROR_STATUS_BIT <= 1'b0;
            toggle_prev <= 1'b0;
            toggle_prev_ok <= 1'b0;
        end else if (seq_end && !refused && cur_reset) begin
            FLASH_BUSY <= 1'b0;
            ERROR_STATUS_BIT <= 1'b0; // see RL17
            toggle_prev_ok <= 1'b0;
        end else if (seq_end && !refused && starts_op) begin
            FLASH_BUSY <= 1'b1;
            toggle_prev_ok <= 1'b0;
        end else if (poll) begin
            toggle_prev <= cyc_rdata[`NVM_TOGGLE_BIT];
            toggle_prev_ok <= 1'b1;
            if (toggle_prev_ok && !toggling) begin
                FLASH_BUSY <= 1'b0;
            end
            if (toggling && cyc_rdata[`NVM_ERROR_BIT]) begin
                ERROR_STATUS_BIT <= 1'b1; // see RL17
            end
        end
    end

    // EEPROM mode tracking; write protection is assumed off after reset.
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            SOFTWARE_WRITE_PROTECT <= 1'b0;
            OTP_READ_MODE <= 1'b0;
            EE_POWERED_DOWN <= 1'b0;
        end else if (seq_end && !refused) begin
            case (cur.cmd)
                nvm_pkg::CMD_SDP_WRITE_ENTER: SOFTWARE_WRITE_PROTECT <= 1'b1; // see RL11
                nvm_pkg::CMD_SDP_DISABLE: SOFTWARE_WRITE_PROTECT <= 1'b0; // see RL12
                nvm_pkg::CMD_OTP_READ_ENTER: OTP_READ_MODE <= 1'b1; // see RL3
                nvm_pkg::CMD_EE_POWER_DOWN: EE_POWERED_DOWN <= 1'b1; // see RL10
                nvm_pkg::CMD_EE_RETURN: begin
                    OTP_READ_MODE <= 1'b0; // see RL15
                    EE_POWERED_DOWN <= 1'b0;
                end
                default: EE_POWERED_DOWN <= EE_POWERED_DOWN;
            endcase
        end
    end

endmodule : nvm_command_decoder

// *** hw/nvm_defs.svh ***
// Constants for the nonvolatile memory command sequencer: codes, addresses and timing.
`ifndef NVM_DEFS_SVH
`define NVM_DEFS_SVH

// Command bytes written on the data bus.
`define NVM_UNLOCK1 8'haa
`define NVM_UNLOCK2 8'h55
`define NVM_AUTOSEL 8'h90
`define NVM_PROGRAM 8'ha0
`define NVM_ERASE_SETUP 8'h80
`define NVM_SECTOR_ERASE 8'h30
`define NVM_CHIP_ERASE 8'h10
`define NVM_SUSPEND 8'hb0
`define NVM_RESUME 8'h30
`define NVM_EE_POWER_DOWN 8'h30
`define NVM_SDP_OFF 8'h20
`define NVM_OTP_WRITE 8'hb0
`define NVM_RETURN 8'hf0

// Unlock addresses, compared on the low twelve address bits only.
`define NVM_ADDR_UNLOCK1 12'h555
`define NVM_ADDR_UNLOCK2 12'haaa
`define NVM_CMD_ADDR_W 12

// Address bit positions used by identifier, protection and one-time row reads.
`define NVM_A6 6
`define NVM_A1 1
`define NVM_A0 0
`define NVM_OTP_IDX_W 6

// Status bits returned while an embedded flash operation runs.
`define NVM_TOGGLE_BIT 6
`define NVM_ERROR_BIT 5

// Window for adding further sectors to a sector erase.
`define NVM_ERASE_WINDOW_NS 80000
`define NVM_CLK_PERIOD_NS 40
`define NVM_ERASE_WINDOW_CYC (`NVM_ERASE_WINDOW_NS / `NVM_CLK_PERIOD_NS)

`endif

// *** hw/nvm_pkg.sv ***
// Types shared by the command sequencer and its bus cycle engine.
package nvm_pkg;

    typedef enum logic [4:0] {
        CMD_READ_ID = 5'h00,
        CMD_READ_PROT = 5'h01,
        CMD_OTP_READ_ENTER = 5'h02,
        CMD_PROGRAM = 5'h03,
        CMD_SECTOR_ERASE = 5'h04,
        CMD_ADD_SECTOR = 5'h05,
        CMD_CHIP_ERASE = 5'h06,
        CMD_SUSPEND = 5'h07,
        CMD_RESUME = 5'h08,
        CMD_EE_POWER_DOWN = 5'h09,
        CMD_SDP_WRITE_ENTER = 5'h0a,
        CMD_SDP_DISABLE = 5'h0b,
        CMD_OTP_WRITE_ENTER = 5'h0c,
        CMD_EE_RETURN = 5'h0d,
        CMD_FLASH_RESET_LONG = 5'h0e,
        CMD_FLASH_RESET_SHORT = 5'h0f,
        CMD_PLAIN_READ = 5'h10,
        CMD_PLAIN_WRITE = 5'h11
    } cmd_e;

    typedef enum logic [2:0] {
        ADR_UNLOCK1 = 3'h0,
        ADR_UNLOCK2 = 3'h1,
        ADR_USER = 3'h2,
        ADR_ID = 3'h3,
        ADR_PROT = 3'h4
    } adr_e;

    typedef struct packed {
        cmd_e cmd;
        logic is_eeprom;
        logic [2:0] sector;
        logic [15:0] addr;
        logic [7:0] data;
    } req_s;

    typedef struct packed {
        logic last;
        logic is_read;
        adr_e akind;
        logic [7:0] data;
    } step_s;

    typedef struct packed {
        logic is_read;
        logic [15:0] addr;
        logic [7:0] data;
        logic [7:0] fsel;
        logic [3:0] esel;
    } cycle_s;

endpackage : nvm_pkg
